/* design/dcc_defines.svh */
// Purpose: offsets, field positions and reset values of the comparator control
// Assumes: APB with 32-bit words
// Notes: control/status word layout follows the shared two-half format
`ifndef DCC_DEFINES_SVH
`define DCC_DEFINES_SVH

`define DCC_OFF_CS       12'h000
`define DCC_OFF_ISTAT    12'h004
`define DCC_OFF_IMASK    12'h008
`define DCC_OFF_EVEN     12'h00C
`define DCC_CS_RESET     32'h00000000
`define DCC_HALF_W       16
`define DCC_B_EN         0
`define DCC_B_SW         1
`define DCC_B_MODE       2
`define DCC_B_MSEL       4
`define DCC_B_WND        7
`define DCC_B_OSEL       8
`define DCC_B_POL        11
`define DCC_B_HST        12
`define DCC_B_OUT        14
`define DCC_B_LOCK       15
`define DCC_HALF_WMASK   16'h3FFF
`define DCC_HALF_RESET   16'h0000

`endif

/* design/dcc_half_if.sv */
// Purpose: carries one comparator half's settings and routed results
// Assumes: used between the top and its per-comparator path
// Notes: path side is purely combinational
interface dcc_half_if;
	logic                   raw_out;
	logic                   polarity;
	logic [2:0]             dest;
	logic                   final_out;
	dcc_pkg::dcc_route_t    route;

	modport ctrl (output raw_out, output polarity, output dest,
		input final_out, input route);
	modport path (input raw_out, input polarity, input dest,
		output final_out, output route);
endinterface : dcc_half_if

/* design/dcc_irq_sync.sv */
// Purpose: brings an asynchronous comparator level into the clock domain
// Assumes: level input may change at any time
// Notes: rise and fall pulses compare the second and third stages
module dcc_irq_sync (
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic reset,
	// level in, edges out
	input  wire logic level_in,
	output logic      level_sync,
	output logic      rise,
	output logic      fall
);
	logic stage1;
	logic stage2;
	logic stage3;

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			stage1 <= 1'b0;
			stage2 <= 1'b0;
			stage3 <= 1'b0;
		end else begin
			stage1 <= level_in;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	assign level_sync = stage2;
	assign rise       = stage2 & ~stage3;
	assign fall       = ~stage2 & stage3;
endmodule : dcc_irq_sync

/* design/dcc_output_path.sv */
// Purpose: polarity and destination routing of one comparator output
// Assumes: settings are static flops, comparator output is asynchronous
// Notes: no clock here so routing keeps working with the bus clock stopped
module dcc_output_path (
	// settings and results
	dcc_half_if.path hp
);
	wire        pol_out;
	wire [7:0]  onehot;

	assign pol_out      = hp.raw_out ^ hp.polarity;                    // [RL11] [RL8]
	assign hp.final_out = pol_out;                                     // [RL6]
	assign onehot       = 8'h01 << hp.dest;                            // [RL12]
	assign hp.route.brk0         = pol_out & onehot[1];                // [RL7]
	assign hp.route.capture[0]   = pol_out & onehot[2];
	assign hp.route.ref_clear[0] = pol_out & onehot[3];
	assign hp.route.capture[1]   = pol_out & onehot[4];
	assign hp.route.ref_clear[1] = pol_out & onehot[5];
	assign hp.route.capture[2]   = pol_out & onehot[6];
	assign hp.route.ref_clear[2] = pol_out & onehot[7];
endmodule : dcc_output_path

/* design/dcc_pkg.sv */
// Purpose: types shared by the comparator control modules
// Assumes: nothing beyond the defines header
// Notes: speed code order runs fastest to slowest
package dcc_pkg;
	typedef enum logic [1:0] {
		DCC_SPEED_HIGH,
		DCC_SPEED_MEDIUM,
		DCC_SPEED_LOW,
		DCC_SPEED_ULTRA_LOW
	} dcc_speed_t;

	typedef struct packed {
		logic       brk0;
		logic [2:0] capture;
		logic [2:0] ref_clear;
	} dcc_route_t;
endpackage : dcc_pkg

/* design/dcc_top.sv */
// Purpose: digital control of a pair of comparators behind an APB slave
// Assumes: comparator outputs asynchronous; all other inputs synchronous to clk_sys
// Notes: output polarity and routing are combinational from the comparator pins
//
// Function
// RL1: second lock makes bits 31:16 read-only
// RL2: first lock makes bits 15:0 read-only
// RL3: lock stays set until system reset
// RL4: window mode feeds first plus input to second
// RL5: mode 00 fastest, 11 slowest lowest power
// RL6: output goes to timer and pin together
// RL7: routes to capture, break and reference-clear inputs
// RL8: polarity and pin routing need no clock
// RL9: each output has its own interrupt line
// RL10: line gives interrupt or event, both wake
// RL11: polarity 0 passes, 1 inverts output
// RL12: destination 000 none, 001 first break input
// RL13: locked writes ignored silently, no error
`include "dcc_defines.svh"

module dcc_top (
	// clock and reset
	input  wire logic                 clk_sys,
	input  wire logic                 reset,
	// apb slave
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [11:0]          paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	// analog front end
	input  wire logic [1:0]           comp_raw,
	output logic      [1:0]           comp_enable,
	output logic                      first_switch,
	output logic      [1:0]           hysteresis_0,
	output logic      [1:0]           hysteresis_1,
	output logic      [2:0]           minus_select_0,
	output logic      [2:0]           minus_select_1,
	output logic                      window_plus_from_first,
	output dcc_pkg::dcc_speed_t       speed_power_mode_0,
	output dcc_pkg::dcc_speed_t       speed_power_mode_1,
	// outputs to pins and timers
	output logic      [1:0]           comp_pin,
	output logic                      timer0_break,
	output logic      [2:0]           timer_capture,
	output logic      [2:0]           timer_output_reference_clear,
	// external interrupt lines and interrupt
	output logic      [1:0]           external_interrupt_line,
	output logic      [1:0]           wake_event,
	output logic                      irq
);
	logic [15:0] half_lo;
	logic [15:0] half_hi;
	logic [3:0]  int_status;
	logic [3:0]  int_mask;
	logic [3:0]  event_enable;

	wire         first_half_lock  = half_lo[`DCC_B_LOCK];
	wire         second_half_lock = half_hi[`DCC_B_LOCK];
	wire         window_mode_enable = half_hi[`DCC_B_WND];

	// apb decode
	wire         access      = psel & penable;
	wire         wr_en       = access & pwrite;
	wire         rd_en       = access & ~pwrite;
	wire         sel_cs      = (paddr == `DCC_OFF_CS);
	wire         sel_istat   = (paddr == `DCC_OFF_ISTAT);
	wire         sel_imask   = (paddr == `DCC_OFF_IMASK);
	wire         sel_even    = (paddr == `DCC_OFF_EVEN);
	wire         mapped      = sel_cs | sel_istat | sel_imask | sel_even;
	wire         wr_cs_lo    = wr_en & sel_cs & ~first_half_lock;      // [RL2] [RL13]
	wire         wr_cs_hi    = wr_en & sel_cs & ~second_half_lock;     // [RL1] [RL13]
	wire         clr_istat   = rd_en & sel_istat;

	function automatic logic [15:0] merge_half(input logic [15:0] cur,
		input logic [15:0] wdat);
		logic [15:0] wmask;
		wmask = `DCC_HALF_WMASK;
		// lock bit can only be set; output-state bit stays hardware owned
		merge_half = (wdat & wmask) | (cur & (16'h8000 | 16'h4000));   // [RL3]
		merge_half[`DCC_B_LOCK] = cur[`DCC_B_LOCK] | wdat[`DCC_B_LOCK];
	endfunction : merge_half

	// second half has no switch bit; window bit lives there
	wire [15:0]  next_half_lo = merge_half(half_lo, pwdata[15:0]) & 16'hFF7F;
	wire [15:0]  next_half_hi = merge_half(half_hi, pwdata[31:16]) & 16'hFFFD;

	// speed code maps straight onto the mode type, 0 fastest, 3 slowest
	function automatic dcc_pkg::dcc_speed_t speed_of(input logic [1:0] code);
		speed_of = dcc_pkg::dcc_speed_t'(code);                        // [RL5]
	endfunction : speed_of

	// fields of the first comparator's half
	wire         en_0     = half_lo[`DCC_B_EN];
	wire         switch_0 = half_lo[`DCC_B_SW];
	wire [1:0]   mode_0   = half_lo[`DCC_B_MODE +: 2];
	wire [2:0]   msel_0   = half_lo[`DCC_B_MSEL +: 3];
	wire [2:0]   dest_0   = half_lo[`DCC_B_OSEL +: 3];
	wire         pol_0    = half_lo[`DCC_B_POL];
	wire [1:0]   hyst_0   = half_lo[`DCC_B_HST +: 2];

	// fields of the second comparator's half
	wire         en_1     = half_hi[`DCC_B_EN];
	wire [1:0]   mode_1   = half_hi[`DCC_B_MODE +: 2];
	wire [2:0]   msel_1   = half_hi[`DCC_B_MSEL +: 3];
	wire [2:0]   dest_1   = half_hi[`DCC_B_OSEL +: 3];
	wire         pol_1    = half_hi[`DCC_B_POL];
	wire [1:0]   hyst_1   = half_hi[`DCC_B_HST +: 2];

	// per-comparator paths
	dcc_half_if  hp0 ();
	dcc_half_if  hp1 ();

	assign hp0.raw_out  = comp_raw[0];
	assign hp0.polarity = pol_0;                                       // [RL11]
	assign hp0.dest     = dest_0;                                      // [RL12]
	assign hp1.raw_out  = comp_raw[1];
	assign hp1.polarity = pol_1;                                       // [RL11]
	assign hp1.dest     = dest_1;                                      // [RL12]

	dcc_output_path u_path0 (
		.hp (hp0.path)
	);
	dcc_output_path u_path1 (
		.hp (hp1.path)
	);

	// pin and timer outputs work straight from the comparator, no clock
	assign comp_pin[0] = hp0.final_out;                                // [RL6] [RL8]
	assign comp_pin[1] = hp1.final_out;                                // [RL6] [RL8]
	// both comparators may pick one destination; their outputs are or-ed there
	assign timer0_break = hp0.route.brk0 | hp1.route.brk0;             // [RL7]
	assign timer_capture[0] = hp0.route.capture[0] | hp1.route.capture[0];
	assign timer_capture[1] = hp0.route.capture[1] | hp1.route.capture[1];
	assign timer_capture[2] = hp0.route.capture[2] | hp1.route.capture[2];
	assign timer_output_reference_clear[0] = hp0.route.ref_clear[0] | hp1.route.ref_clear[0];
	assign timer_output_reference_clear[1] = hp0.route.ref_clear[1] | hp1.route.ref_clear[1];
	assign timer_output_reference_clear[2] = hp0.route.ref_clear[2] | hp1.route.ref_clear[2];

	// analog settings
	assign comp_enable    = {en_1, en_0};
	assign first_switch   = switch_0;
	assign hysteresis_0   = hyst_0;
	assign hysteresis_1   = hyst_1;
	assign minus_select_0 = msel_0;
	assign minus_select_1 = msel_1;
	assign window_plus_from_first = window_mode_enable;                // [RL4]
	assign speed_power_mode_0 = speed_of(mode_0);                      // [RL5]
	assign speed_power_mode_1 = speed_of(mode_1);                      // [RL5]

	// output of each comparator, sampled into the clock domain for the edge flags
	logic [1:0] out_sync;
	logic [1:0] out_rise;
	logic [1:0] out_fall;

	dcc_irq_sync u_sync0 (
		.clk_sys    (clk_sys),
		.reset      (reset),
		.level_in   (hp0.final_out),
		.level_sync (out_sync[0]),
		.rise       (out_rise[0]),
		.fall       (out_fall[0])
	);
	dcc_irq_sync u_sync1 (
		.clk_sys    (clk_sys),
		.reset      (reset),
		.level_in   (hp1.final_out),
		.level_sync (out_sync[1]),
		.rise       (out_rise[1]),
		.fall       (out_fall[1])
	);

	// dedicated line carries the polarised output level, no clock needed for wake
	assign external_interrupt_line = comp_pin;                         // [RL9]
	// status bits: [1:0] rising edges, [3:2] falling edges
	wire [3:0]   hw_events  = {out_fall, out_rise};
	// a read clears only what it returned, so an edge in its setup cycle survives
	wire [3:0]   rd_clear   = clr_istat ? prdata[3:0] : 4'h0;
	wire [3:0]   next_istat = hw_events | (int_status & ~rd_clear);
	wire [3:0]   wake_src   = hw_events & event_enable;

	// first half: software fields unless locked, output state from the synchroniser
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset)
			half_lo <= `DCC_HALF_RESET;                                 // [RL3]
		else if (wr_cs_lo)
			half_lo <= next_half_lo;
		else
			half_lo[`DCC_B_OUT] <= out_sync[0];
	end

	// second half: same scheme under its own lock
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset)
			half_hi <= `DCC_HALF_RESET;                                 // [RL3]
		else if (wr_cs_hi)
			half_hi <= next_half_hi;
		else
			half_hi[`DCC_B_OUT] <= out_sync[1];
	end

	// sticky edge flags; a new edge wins over the clearing read
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset)
			int_status <= 4'h0;
		else
			int_status <= next_istat;                                  // [RL10]
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset)
			int_mask <= 4'h0;
		else if (wr_en & sel_imask)
			int_mask <= pwdata[3:0];
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset)
			event_enable <= 4'h0;
		else if (wr_en & sel_even)
			event_enable <= pwdata[3:0];
	end

	// interrupt and wake event both come from the same edges
	assign irq           = |(int_status & int_mask);                   // [RL10]
	// each comparator wakes on its own enabled rising or falling edge
	assign wake_event[0] = wake_src[0] | wake_src[2];                  // [RL10]
	assign wake_event[1] = wake_src[1] | wake_src[3];                  // [RL10]

	// read words; output state bits show the synchronised level
	wire [31:0]  cs_word    = {half_hi[15], out_sync[1], half_hi[13:0],
		half_lo[15], out_sync[0], half_lo[13:0]};
	wire [31:0]  istat_word = {28'h0000000, int_status};
	wire [31:0]  imask_word = {28'h0000000, int_mask};
	wire [31:0]  even_word  = {28'h0000000, event_enable};
	wire [31:0]  rd_mux     = sel_cs    ? cs_word :
		sel_istat ? istat_word :
		sel_imask ? imask_word :
		sel_even  ? even_word : 32'h00000000;

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset)
			prdata <= 32'h00000000;
		else if (psel & ~penable & ~pwrite)
			prdata <= rd_mux;
	end

	// zero wait state; unmapped answers error, locked writes do not
	assign pready  = 1'b1;
	assign pslverr = access & ~mapped;                                 // [RL13]
endmodule : dcc_top

/* verif/dcc_far_model.sv */
// Purpose: interrupt controller and pin side seen by the comparator control
// Assumes: wake pulses last one clk_sys cycle
// Notes: counts wake events, passes the line level through
module dcc_far_model (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       reset,
	// lines from the block
	input  wire logic [1:0] wake_event,
	input  wire logic [1:0] external_interrupt_line,
	// seen by the bench
	output int              wakes,
	output logic      [1:0] line_seen
);
	timeunit 1ns;
	timeprecision 1ns;
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) wakes <= 0;
		else wakes <= wakes + 32'(wake_event[0]) + 32'(wake_event[1]);
	end
	assign line_seen = external_interrupt_line;
endmodule : dcc_far_model

/* verif/dcc_top_asserts.sv */
// Purpose: port-level checks of dcc_top
// Assumes: shadow of the control word follows apb writes
// Notes: output state bits are not shadowed
`include "dcc_defines.svh"
module dcc_top_asserts (
	// clock and reset
	input wire logic                clk_sys,
	input wire logic                reset,
	// apb
	input wire logic                psel,
	input wire logic                penable,
	input wire logic                pwrite,
	input wire logic [11:0]         paddr,
	input wire logic [31:0]         pwdata,
	input wire logic [31:0]         prdata,
	input wire logic                pslverr,
	// comparator side
	input wire logic [1:0]          comp_raw,
	input wire logic [1:0]          comp_pin,
	input wire logic                window_plus_from_first,
	input wire dcc_pkg::dcc_speed_t speed_power_mode_1,
	input wire logic                timer0_break,
	input wire logic [2:0]          timer_output_reference_clear,
	input wire logic [1:0]          external_interrupt_line
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] cs;
	wire         wr = psel && penable && pwrite && paddr == `DCC_OFF_CS;
	wire         rd = psel && !penable && !pwrite && paddr == `DCC_OFF_CS;
	// a locked half keeps its old value, lock bits included
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) cs <= '0;
		else if (wr) cs <= {cs[31] ? cs[31:16] : pwdata[31:16], cs[15] ? cs[15:0] : pwdata[15:0]};
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	property p_pol; comp_pin == (comp_raw ^ {cs[27], cs[11]}); endproperty
	a_pol: assert property (p_pol) else $error("pin polarity wrong");
	property p_external_interrupt_line; external_interrupt_line == comp_pin; endproperty
	a_external_interrupt_line: assert property (p_external_interrupt_line) else $error("interrupt line wrong");
	property p_wnd; window_plus_from_first == cs[23]; endproperty
	a_wnd: assert property (p_wnd) else $error("window mode wrong");
	property p_mode; speed_power_mode_1 == dcc_pkg::dcc_speed_t'(cs[19:18]); endproperty
	a_mode: assert property (p_mode) else $error("speed mode wrong");
	property p_brk; timer0_break == (cs[10:8] == 3'h1 && comp_pin[0]
		|| cs[26:24] == 3'h1 && comp_pin[1]); endproperty
	a_brk: assert property (p_brk) else $error("break route wrong");
	property p_ref; timer_output_reference_clear[0] == (cs[10:8] == 3'h3 && comp_pin[0]
		|| cs[26:24] == 3'h3 && comp_pin[1]); endproperty
	a_ref: assert property (p_ref) else $error("clear route wrong");
	property p_rd; rd |=> {prdata[31], prdata[27:18], prdata[15], prdata[11:8]}
		== $past({cs[31], cs[27:18], cs[15], cs[11:8]}); endproperty
	a_rd: assert property (p_rd) else $error("control word read wrong");
	property p_err; psel && penable && paddr[11:4] != 8'h00 |-> pslverr; endproperty
	a_err: assert property (p_err) else $error("no error on unmapped");
	property p_ok; psel && penable && paddr == `DCC_OFF_CS |-> !pslverr; endproperty
	a_ok: assert property (p_ok) else $error("error on control word");
	c_lock: cover property (wr && cs[15]);
	c_err: cover property (psel && penable && pslverr);
	c_brk: cover property (timer0_break);
endmodule : dcc_top_asserts
bind dcc_top dcc_top_asserts u_dcc_top_asserts (.clk_sys, .reset, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pslverr, .comp_raw, .comp_pin, .window_plus_from_first,
	.speed_power_mode_1, .timer0_break, .timer_output_reference_clear, .external_interrupt_line);

/* verif/dcc_top_tb.sv */
// Purpose: self-checking bench of dcc_top
// Assumes: zero-wait apb slave
// Notes: read data checked by a monitor against queued notes
`include "dcc_defines.svh"
module dcc_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_sys, reset, psel, penable, pwrite, pready, pslverr;
	logic        timer0_break, window_plus_from_first, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, exp_q[$];
	logic [1:0]  comp_raw, comp_pin, external_interrupt_line, wake_event, line_seen;
	logic [2:0]  timer_capture, timer_output_reference_clear;
	logic [2:0]  minus_select_0, minus_select_1;
	logic [1:0]  comp_enable, hysteresis_0, hysteresis_1;
	logic        first_switch;
	logic [15:0] lfsr;
	logic [6:0]  exp7;
	int          err_count, num_checks, wakes;
	dcc_pkg::dcc_speed_t speed_power_mode_0, speed_power_mode_1;
	dcc_top u_dcc_top (.clk_sys, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .comp_raw, .comp_enable, .first_switch, .hysteresis_0,
		.hysteresis_1, .minus_select_0, .minus_select_1, .window_plus_from_first,
		.speed_power_mode_0, .speed_power_mode_1, .comp_pin, .timer0_break, .timer_capture,
		.timer_output_reference_clear, .external_interrupt_line, .wake_event, .irq);
	dcc_far_model u_dcc_far_model (.clk_sys, .reset, .wake_event, .external_interrupt_line,
		.wakes, .line_seen);
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : check
	task automatic finish_test;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : finish_test
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr_next
	// read notes are queued at setup, taken at the access edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		if (!w) exp_q.push_back(d);
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys iff pready === 1'b1);
		check(pslverr, e);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// output state bits masked: they lag the comparator by the synchroniser
	always @(posedge clk_sys) begin
		if (psel && penable && !pwrite && pready)
			check(prdata & 32'hBFFF_BFFF, exp_q.pop_front() & 32'hBFFF_BFFF);
	end
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (5000) @(posedge clk_sys);
		err_count++;
		finish_test;
	end
	initial begin
		{reset, psel, penable, pwrite, paddr, pwdata, comp_raw} = {1'b1, 49'h0};
		{err_count, num_checks, lfsr} = {64'h0, 16'h840C};
		repeat (5) @(posedge clk_sys);
		reset <= 1'b0;
		apb(0, `DCC_OFF_CS, 0, 0);
		apb(0, 12'h010, 0, 1);
		apb(1, `DCC_OFF_IMASK, 1, 0);
		apb(1, `DCC_OFF_EVEN, 1, 0);
		comp_raw <= 2'b01;
		repeat (4) @(posedge clk_sys);
		@(negedge clk_sys);
		check(irq, 1'b1);
		check(wakes, 1);
		apb(0, `DCC_OFF_ISTAT, 1, 0);
		@(negedge clk_sys);
		check(irq, 1'b0);
		apb(1, `DCC_OFF_IMASK, 0, 0);
		comp_raw <= 2'b00;
		repeat (4) @(posedge clk_sys);
		@(negedge clk_sys);
		check(irq, 1'b0);
		apb(0, `DCC_OFF_ISTAT, 4, 0);
		for (int i = 0; i < 8; i++) begin
			lfsr = lfsr_next(lfsr);
			@(posedge clk_sys);
			comp_raw <= lfsr[1:0];
			apb(1, `DCC_OFF_CS, {8'h00, i[0], 3'h0, ~i[1:0], 2'h0,
				4'h0, 1'b1, i[2:0], 4'h0, i[1:0], 2'h1}, 0);
			exp7 = (i == 0) ? 7'h00 : (i == 1) ? 7'h40 :
				i[0] ? 7'h01 << ((i - 3) / 2) : 7'h08 << ((i - 2) / 2);
			if (lfsr[0]) exp7 = 7'h00;
			@(negedge clk_sys);
			check(comp_pin, {lfsr[1], ~lfsr[0]});
			check(line_seen, {lfsr[1], ~lfsr[0]});
			check({timer0_break, timer_capture, timer_output_reference_clear}, exp7);
			check(speed_power_mode_0, i[1:0]);
			check(window_plus_from_first, i[0]);
		end
		// enable, switch, minus-select and hysteresis fields of both halves; reserved bits 7 and 17 read back 0
		apb(1, `DCC_OFF_CS, 32'h1063_20D3, 0);
		apb(0, `DCC_OFF_CS, 32'h1061_2053, 0);
		check({comp_enable, first_switch, hysteresis_0, hysteresis_1}, 7'h79);
		check({minus_select_0, minus_select_1}, 6'h2E);
		apb(1, `DCC_OFF_CS, 32'h0000_8800, 0);
		apb(1, `DCC_OFF_CS, 0, 0);
		apb(0, `DCC_OFF_CS, 32'h0000_8800, 0);
		apb(1, `DCC_OFF_CS, 32'h8800_0000, 0);
		apb(1, `DCC_OFF_CS, 32'hFFFF_FFFF, 0);
		apb(0, `DCC_OFF_CS, 32'h8800_8800, 0);
		@(negedge clk_sys);
		check(comp_pin, {~comp_raw});
		@(posedge clk_sys);
		reset <= 1'b1;
		@(posedge clk_sys);
		reset <= 1'b0;
		apb(0, `DCC_OFF_CS, 0, 0);
		apb(1, `DCC_OFF_CS, 32'h0800_0800, 0);
		apb(0, `DCC_OFF_CS, 32'h0800_0800, 0);
		finish_test;
	end
endmodule : dcc_top_tb
